// >>> rtl/aux_ctl_pkg.sv
// shared constants and types for the auxiliary-space flash host controller
package aux_ctl_pkg;
    // ----------------------------------------
    // software register map
    // ----------------------------------------
    localparam logic [3:0] REG_CMD = 4'h0;
    localparam logic [3:0] REG_ADDR = 4'h1;
    localparam logic [3:0] REG_DATA = 4'h2;
    localparam logic [3:0] REG_STATUS = 4'h3;
    localparam logic [3:0] REG_RDATA = 4'h4;
    localparam int ST_BUSY = 0;
    localparam int ST_ERR = 1;
    localparam int ST_OPEN = 2;
    localparam int ST_REM_LSB = 8;
    // ----------------------------------------
    // operation codes written to the command register
    // ----------------------------------------
    localparam logic [3:0] OP_WRITE = 4'h1;
    localparam logic [3:0] OP_READ = 4'h2;
    localparam logic [3:0] OP_STATUS = 4'h3;
    localparam logic [3:0] OP_RESET = 4'h4;
    localparam logic [3:0] OP_EXIT = 4'h5;
    localparam logic [3:0] OP_SEC_EXIT = 4'h6;
    localparam logic [3:0] OP_WORD_PROG = 4'h7;
    localparam logic [3:0] OP_BUF_START = 4'h8;
    localparam logic [3:0] OP_BUF_WORD = 4'h9;
    // ----------------------------------------
    // device command pairs
    // ----------------------------------------
    localparam logic [15:0] CMD_RESET = 16'h00f0;
    localparam logic [15:0] CMD_STATUS_READ = 16'h0070;
    localparam logic [15:0] CMD_UNLOCK1 = 16'h00aa;
    localparam logic [15:0] CMD_UNLOCK2 = 16'h0055;
    localparam logic [15:0] CMD_WORD_PROG = 16'h00a0;
    localparam logic [15:0] CMD_BUF_LOAD = 16'h0025;
    localparam logic [15:0] CMD_BUF_CONFIRM = 16'h0029;
    localparam logic [15:0] CMD_EXIT_ENTRY = 16'h0090;
    localparam logic [15:0] CMD_EXIT = 16'h0000;
    localparam logic [23:0] ADDR_UNLOCK1 = 24'h000555;
    localparam logic [23:0] ADDR_UNLOCK2 = 24'h0002aa;
    localparam logic [15:0] MAX_COUNT = 16'h0100;
    localparam int PAGE_LSB = 8;
    // ----------------------------------------
    // bus timing
    // ----------------------------------------
    localparam int CLOCK_NS = 20;
    localparam int WE_PULSE_NS = 35;
    localparam int READ_ACC_NS = 100;
    localparam int RECOVER_NS = 20;
    localparam int SYNC_STAGES = 2;
    localparam logic [3:0] WE_CYC = 4'((WE_PULSE_NS + CLOCK_NS - 1) / CLOCK_NS);
    localparam logic [3:0] RD_CYC = 4'((READ_ACC_NS + CLOCK_NS - 1) / CLOCK_NS + SYNC_STAGES);
    localparam logic [3:0] REC_CYC = 4'((RECOVER_NS + CLOCK_NS - 1) / CLOCK_NS);
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef struct packed {
        logic [23:0] addr;
        logic [15:0] data;
        logic rd;
        logic last;
    } bus_pair_type;
    typedef enum logic [1:0] {bus_idle, bus_drive, bus_strobe, bus_recover} bus_state_type;
endpackage

// >>> rtl/aux_space_host.sv
// host controller issuing auxiliary-space command sequences to a parallel flash
//
// Operation
// - in secure mode reads give secure data, F0h exits, and AAh at 555h starts the unlock.
// - the first unlock state needs 55h at 2AAh to reach the second, and F0h there exits to array read.
// - the second unlock state takes A0h at 555h, 25h at a sector or 90h at 555h, and F0h goes back to secure mode.
// - after buffer entry the count goes to the same sector, and a count above 256 or another sector aborts.
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
module aux_space_host
(
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // software register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // flash pins
    output logic [23:0] flash_addr,
    output logic [15:0] dq_out,
    input wire logic [15:0] dq_in,
    output logic dq_oe_n,
    output logic ce_n,
    output logic oe_n,
    output logic we_n
);
    // ----------------------------------------
    // sequence table
    // ----------------------------------------
    function automatic aux_ctl_pkg::bus_pair_type step_pair(input logic [3:0] op, input logic [1:0] idx,
        input logic [23:0] addr, input logic [15:0] data, input logic [23:0] sa, input logic final_word);
        aux_ctl_pkg::bus_pair_type p;
        logic secure;
        p = '{addr: addr, data: data, rd: 1'b0, last: 1'b1};
        secure = (op == aux_ctl_pkg::OP_SEC_EXIT) || (op == aux_ctl_pkg::OP_WORD_PROG) ||
                 (op == aux_ctl_pkg::OP_BUF_START);
        if (secure && idx == 2'd0)
            p = '{addr: aux_ctl_pkg::ADDR_UNLOCK1, data: aux_ctl_pkg::CMD_UNLOCK1, rd: 1'b0, last: 1'b0};
        else if (secure && idx == 2'd1)
            p = '{addr: aux_ctl_pkg::ADDR_UNLOCK2, data: aux_ctl_pkg::CMD_UNLOCK2, rd: 1'b0, last: 1'b0};
        else if (op == aux_ctl_pkg::OP_READ)
            p.rd = 1'b1;
        else if (op == aux_ctl_pkg::OP_RESET)
            p.data = aux_ctl_pkg::CMD_RESET;
        else if (op == aux_ctl_pkg::OP_STATUS)
            p = (idx == 2'd0) ? '{addr: aux_ctl_pkg::ADDR_UNLOCK1, data: aux_ctl_pkg::CMD_STATUS_READ,
                                  rd: 1'b0, last: 1'b0} : '{addr: addr, data: data, rd: 1'b1, last: 1'b1};
        else if (op == aux_ctl_pkg::OP_EXIT)
            p = (idx == 2'd0) ? '{addr: aux_ctl_pkg::ADDR_UNLOCK1, data: aux_ctl_pkg::CMD_EXIT_ENTRY,
                                  rd: 1'b0, last: 1'b0} : '{addr: addr, data: aux_ctl_pkg::CMD_EXIT,
                                  rd: 1'b0, last: 1'b1};
        else if (op == aux_ctl_pkg::OP_SEC_EXIT)
            p = (idx == 2'd2) ? '{addr: aux_ctl_pkg::ADDR_UNLOCK1, data: aux_ctl_pkg::CMD_EXIT_ENTRY,
                                  rd: 1'b0, last: 1'b0} : '{addr: addr, data: aux_ctl_pkg::CMD_EXIT,
                                  rd: 1'b0, last: 1'b1};
        else if (op == aux_ctl_pkg::OP_WORD_PROG)
            p = (idx == 2'd2) ? '{addr: aux_ctl_pkg::ADDR_UNLOCK1, data: aux_ctl_pkg::CMD_WORD_PROG,
                                  rd: 1'b0, last: 1'b0} : '{addr: addr, data: data, rd: 1'b0, last: 1'b1};
        // buffer entry and count at one sector
        else if (op == aux_ctl_pkg::OP_BUF_START)
            p = (idx == 2'd2) ? '{addr: sa, data: aux_ctl_pkg::CMD_BUF_LOAD, rd: 1'b0, last: 1'b0} :
                                '{addr: sa, data: data, rd: 1'b0, last: 1'b1};
        else if (op == aux_ctl_pkg::OP_BUF_WORD)
            p = (idx == 2'd0) ? '{addr: addr, data: data, rd: 1'b0, last: !final_word} :
                                '{addr: sa, data: aux_ctl_pkg::CMD_BUF_CONFIRM, rd: 1'b0, last: 1'b1};
        return p;
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [23:0] addr_reg;
    logic [15:0] data_reg;
    logic [3:0] op;
    logic [1:0] step;
    logic busy;
    logic err;
    logic [15:0] rdata;
    logic [23:0] sa;
    logic [8:0] remaining;
    logic buf_open;
    logic final_word;
    logic [15:0] dq_meta;
    logic [15:0] dq_sync;
    aux_ctl_pkg::bus_state_type bus_st;
    logic [3:0] timer;

    // ----------------------------------------
    // command decode
    // ----------------------------------------
    wire aux_ctl_pkg::bus_pair_type cur = step_pair(op, step, addr_reg, data_reg, sa, final_word);
    wire cmd_wr = reg_write && (reg_addr == aux_ctl_pkg::REG_CMD);
    wire [3:0] new_op = reg_wdata[3:0];
    wire page_ok = addr_reg[23:aux_ctl_pkg::PAGE_LSB] == sa[23:aux_ctl_pkg::PAGE_LSB];
    wire count_bad = (new_op == aux_ctl_pkg::OP_BUF_START) && (data_reg > aux_ctl_pkg::MAX_COUNT);
    wire word_bad = (new_op == aux_ctl_pkg::OP_BUF_WORD) && (!buf_open || remaining == 9'h000 || !page_ok);
    wire refuse = cmd_wr && (busy || count_bad || word_bad);
    wire accept = cmd_wr && !refuse;
    wire step_done = (bus_st == aux_ctl_pkg::bus_recover) && (timer == 4'h0);
    wire err_clear = reg_write && (reg_addr == aux_ctl_pkg::REG_STATUS) && reg_wdata[aux_ctl_pkg::ST_ERR];
    wire [31:0] status_word = {15'h0000, remaining, 5'h00, buf_open, err, busy};
    wire [31:0] next_rdata = (reg_addr == aux_ctl_pkg::REG_ADDR) ? {8'h00, addr_reg} :
                             (reg_addr == aux_ctl_pkg::REG_DATA) ? {16'h0000, data_reg} :
                             (reg_addr == aux_ctl_pkg::REG_STATUS) ? status_word :
                             (reg_addr == aux_ctl_pkg::REG_RDATA) ? {16'h0000, rdata} : 32'h0000_0000;

    // ----------------------------------------
    // software registers
    // ----------------------------------------
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            addr_reg <= 24'h000000;
            data_reg <= 16'h0000;
            reg_rdata <= 32'h0000_0000;
            err <= 1'b0;
        end
        else
        begin
            if (reg_write && reg_addr == aux_ctl_pkg::REG_ADDR)
                addr_reg <= reg_wdata[23:0];
            if (reg_write && reg_addr == aux_ctl_pkg::REG_DATA)
                data_reg <= reg_wdata[15:0];
            reg_rdata <= reg_read ? next_rdata : 32'h0000_0000;
            // a refusal in the clearing cycle still stands
            err <= refuse || (err && !err_clear);
        end
    end

    // ----------------------------------------
    // buffer bookkeeping
    // ----------------------------------------
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            sa <= 24'h000000;
            remaining <= 9'h000;
            buf_open <= 1'b0;
            final_word <= 1'b0;
        end
        else if (accept && new_op == aux_ctl_pkg::OP_BUF_START)
        begin
            // count is words minus one, so one more word than written
            sa <= addr_reg;
            remaining <= data_reg[8:0] + 9'h001;
            buf_open <= 1'b1;
            final_word <= 1'b0;
        end
        else if (accept && new_op == aux_ctl_pkg::OP_BUF_WORD)
        begin
            remaining <= remaining - 9'h001;
            buf_open <= remaining != 9'h001;
            final_word <= remaining == 9'h001;
        end
        else if (accept)
            buf_open <= 1'b0;
    end

    // ----------------------------------------
    // pin input sync
    // ----------------------------------------
    always_ff @(posedge clock)
    begin
        dq_meta <= dq_in;
        dq_sync <= dq_meta;
    end

    // ----------------------------------------
    // bus cycle engine
    // ----------------------------------------
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            bus_st <= aux_ctl_pkg::bus_idle;
            op <= 4'h0;
            step <= 2'd0;
            busy <= 1'b0;
            timer <= 4'h0;
            rdata <= 16'h0000;
            flash_addr <= 24'h000000;
            dq_out <= 16'h0000;
            dq_oe_n <= 1'b1;
            ce_n <= 1'b1;
            oe_n <= 1'b1;
            we_n <= 1'b1;
        end
        else
        begin
            case (bus_st)
                aux_ctl_pkg::bus_idle:
                begin
                    if (accept)
                    begin
                        op <= new_op;
                        step <= 2'd0;
                        busy <= 1'b1;
                        bus_st <= aux_ctl_pkg::bus_drive;
                    end
                end
                aux_ctl_pkg::bus_drive:
                begin
                    flash_addr <= cur.addr;
                    dq_out <= cur.data;
                    dq_oe_n <= cur.rd;
                    ce_n <= 1'b0;
                    we_n <= cur.rd;
                    oe_n <= !cur.rd;
                    timer <= cur.rd ? aux_ctl_pkg::RD_CYC - 4'h1 : aux_ctl_pkg::WE_CYC - 4'h1;
                    bus_st <= aux_ctl_pkg::bus_strobe;
                end
                aux_ctl_pkg::bus_strobe:
                begin
                    if (timer == 4'h0)
                    begin
                        // the read word has passed the sync stages by now
                        if (cur.rd)
                            rdata <= dq_sync;
                        we_n <= 1'b1;
                        oe_n <= 1'b1;
                        timer <= aux_ctl_pkg::REC_CYC - 4'h1;
                        bus_st <= aux_ctl_pkg::bus_recover;
                    end
                    else
                        timer <= timer - 4'h1;
                end
                aux_ctl_pkg::bus_recover:
                begin
                    dq_oe_n <= 1'b1;
                    if (timer != 4'h0)
                        timer <= timer - 4'h1;
                    else if (cur.last)
                    begin
                        ce_n <= 1'b1;
                        busy <= 1'b0;
                        bus_st <= aux_ctl_pkg::bus_idle;
                    end
                    else
                    begin
                        step <= step + 2'd1;
                        bus_st <= aux_ctl_pkg::bus_drive;
                    end
                end
                default:
                    bus_st <= aux_ctl_pkg::bus_idle;
            endcase
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    wire wr_issue = (bus_st == aux_ctl_pkg::bus_drive) && !cur.rd;
    wire sec_op = (op == aux_ctl_pkg::OP_SEC_EXIT) || (op == aux_ctl_pkg::OP_WORD_PROG) ||
                  (op == aux_ctl_pkg::OP_BUF_START);

    property p_unlock_first;
        @(posedge clock) disable iff (srst)
        wr_issue && sec_op && step == 2'd0 |=> flash_addr == 24'h000555 && dq_out == 16'h00aa && !dq_oe_n;
    endproperty
    a_unlock_first: assert property (p_unlock_first) else $error("first unlock pair wrong");

    property p_unlock_second;
        @(posedge clock) disable iff (srst)
        wr_issue && sec_op && step == 2'd1 |=> flash_addr == 24'h0002aa && dq_out == 16'h0055;
    endproperty
    a_unlock_second: assert property (p_unlock_second) else $error("second unlock pair wrong");

    property p_we_pulse;
        @(posedge clock) disable iff (srst)
        $fell(we_n) |-> !we_n [*2] ##1 we_n;
    endproperty
    a_we_pulse: assert property (p_we_pulse) else $error("write pulse length wrong");

    property p_prog_entry;
        @(posedge clock) disable iff (srst)
        wr_issue && op == aux_ctl_pkg::OP_WORD_PROG && step == 2'd2 |=> flash_addr == 24'h000555 &&
            dq_out == 16'h00a0 ##1 !we_n;
    endproperty
    a_prog_entry: assert property (p_prog_entry) else $error("word program entry wrong");

    property p_count_sector;
        @(posedge clock) disable iff (srst)
        wr_issue && op == aux_ctl_pkg::OP_BUF_START && step == 2'd3 |=> flash_addr == sa &&
            dq_out <= 16'h0100 && $past(step) == 2'd3;
    endproperty
    a_count_sector: assert property (p_count_sector) else $error("buffer count pair wrong");

    property p_page;
        @(posedge clock) disable iff (srst)
        wr_issue && op == aux_ctl_pkg::OP_BUF_WORD && step == 2'd0 |=>
            flash_addr[23:8] == sa[23:8] ##[1:8] we_n;
    endproperty
    a_page: assert property (p_page) else $error("buffer word outside page");

    property p_exit;
        @(posedge clock) disable iff (srst)
        wr_issue && op == aux_ctl_pkg::OP_EXIT && step == 2'd1 |=> dq_out == 16'h0000 ##[1:8] !busy;
    endproperty
    a_exit: assert property (p_exit) else $error("exit sequence wrong");
endmodule

// >>> bench/flash_aux_model.sv
// behavioural model of the flash device for the auxiliary address spaces
`timescale 1ns/1ns
module flash_aux_model
(
    // flash pins
    input wire logic [23:0] flash_addr,
    input wire logic [15:0] dq_out,
    output logic [15:0] dq_in,
    input wire logic dq_oe_n,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    // bench control
    input wire logic load,
    input wire logic [3:0] start,
    output logic [3:0] state
);
    // states: 0 read, 1 secure, 2 unlock1, 3 unlock2, 4 word entry, 5 count, 6 loading,
    // 7 programming, 8 secure exit, 9 status read, a lock, b lock exit, c query, d lock prog entry
    logic [3:0] ret = 4'h0;
    logic [15:0] held = 16'h0;
    logic [23:0] sect = 24'h0;
    logic ready = 1'b1;
    logic abort = 1'b0;
    logic from_sr = 1'b0;
    int cnt = 0;
    wire logic is555 = flash_addr == 24'h000555;
    wire logic [15:0] rval = (state == 4'h9) ? {8'h00, ready, 3'h0, abort, 3'h0} : {8'ha5, 4'h0, state};
    // no pull on dq: a released bus shows the inverse of the last value
    assign dq_in = (!ce_n && !oe_n) ? rval : ~held;
    initial state = 4'h0;
    always @(posedge load) state = start;
    // the completion time is fixed, so status polling sees a real busy phase
    task automatic start_prog(input logic ab);
        state = 4'h7;
        abort = ab;
        ready = 1'b0;
        ready <= #2000 1'b1;
    endtask
    always @(negedge oe_n) from_sr = !ce_n && (state == 4'h9);
    always @(posedge oe_n)
    begin
        held = rval;
        if (from_sr)
            state = ret;
        from_sr = 1'b0;
    end
    always @(posedge we_n)
    begin
        if (!ce_n && !dq_oe_n)
        begin
            if (is555 && dq_out == 16'h0070 && state inside {4'h1, 4'h2, 4'h7, 4'h8, 4'ha, 4'hc, 4'hd})
            begin
                ret = (state == 4'h2 || state == 4'h8) ? 4'h1 : state;
                state = 4'h9;
            end
            else
                case (state)
                    4'h1: state = (dq_out == 16'h00f0) ? 4'h0 : (is555 && dq_out == 16'h00aa) ? 4'h2 : state;
                    4'h2: state = (dq_out == 16'h00f0) ? 4'h0 :
                        (flash_addr == 24'h0002aa && dq_out == 16'h0055) ? 4'h3 : state;
                    4'h3:
                    begin
                        sect = flash_addr;
                        state = (dq_out == 16'h00f0) ? 4'h1 : (is555 && dq_out == 16'h00a0) ? 4'h4 :
                            (is555 && dq_out == 16'h0090) ? 4'h8 : (dq_out == 16'h0025) ? 4'h5 : state;
                    end
                    4'h4: if (!(is555 && dq_out == 16'h0071)) start_prog(1'b0);
                    4'h5:
                    begin
                        cnt = int'(dq_out);
                        if (dq_out > 16'h0100 || flash_addr != sect)
                            start_prog(1'b1);
                        else
                            state = 4'h6;
                    end
                    4'h6:
                        if (cnt < 0 && dq_out == 16'h0029 && flash_addr == sect)
                            start_prog(1'b0);
                        else if (cnt < 0 || flash_addr[23:8] != sect[23:8])
                            start_prog(1'b1);
                        else
                            cnt = cnt - 1;
                    4'h7:
                        if (ready && is555 && dq_out == 16'h0071)
                            state = 4'h1;
                        else if (ready && !abort && dq_out == 16'h00f0)
                            state = 4'h0;
                        else if (abort && is555 && dq_out == 16'h00aa)
                            state = 4'h2;
                    4'h8: if (dq_out == 16'h0000) state = 4'h0;
                    4'ha: state = (dq_out == 16'h00f0) ? 4'h0 : (dq_out == 16'h0090) ? 4'hb :
                        (dq_out == 16'h00a0) ? 4'hd : state;
                    4'hb: if (dq_out == 16'h0000 || dq_out == 16'h0003) state = 4'h0;
                    4'hc: if (dq_out == 16'h00f0) state = 4'h0;
                    default: state = state;
                endcase
        end
    end
endmodule

// >>> bench/test_aux_space_host.sv
// self-checking bench for the auxiliary-space flash host controller
`timescale 1ns/1ns
module test_aux_space_host;
    typedef struct packed {logic [3:0] st0; logic [3:0] op; logic [23:0] a; logic [15:0] d;
        logic [3:0] st1; logic [31:0] rd;} row_type;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [31:0] reg_rdata;
    logic [23:0] flash_addr;
    logic [15:0] dq_out;
    logic [15:0] dq_in;
    logic dq_oe_n;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic load = 1'b0;
    logic [3:0] start = 4'h0;
    logic [3:0] state;
    logic [31:0] rd_val;
    int err_count = 0;
    int n_compared = 0;
    row_type rows [17];
    initial forever #10 clock = ~clock;
    aux_space_host u_aux_space_host (.clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .flash_addr(flash_addr),
        .dq_out(dq_out), .dq_in(dq_in), .dq_oe_n(dq_oe_n), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n));
    flash_aux_model u_flash_aux_model (.flash_addr(flash_addr), .dq_out(dq_out), .dq_in(dq_in),
        .dq_oe_n(dq_oe_n), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .load(load), .start(start), .state(state));
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask
    task automatic poll;
        int i;
        for (i = 0; i < 200; i++)
        begin
            rd(aux_ctl_pkg::REG_STATUS);
            if (rd_val[aux_ctl_pkg::ST_BUSY] === 1'b0)
                break;
        end
        if (i == 200)
            check("busy", 32'h1, 32'h0);
    endtask
    task automatic run(input logic [23:0] a, input logic [15:0] d, input logic [3:0] op);
        wr(aux_ctl_pkg::REG_ADDR, {8'h00, a});
        wr(aux_ctl_pkg::REG_DATA, {16'h0000, d});
        wr(aux_ctl_pkg::REG_CMD, {28'h0, op});
        poll;
    endtask
    task automatic set_state(input logic [3:0] s);
        start = s;
        load = 1'b1;
        #1 load = 1'b0;
    endtask
    task automatic err_is(input string name, input logic e);
        rd(aux_ctl_pkg::REG_STATUS);
        check(name, {31'h0, rd_val[aux_ctl_pkg::ST_ERR]}, {31'h0, e});
        wr(aux_ctl_pkg::REG_STATUS, 32'h2);
    endtask
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        // whole run needs about a thousand cycles; 10000 cycles leaves ample margin
        #200000;
        err_count++;
        tally_and_finish;
    end
    initial
    begin
        // op codes: 1 write, 2 read, 3 status, 4 reset, 5 exit, 6 secure exit, 7 word program
        rows[0] = '{4'h1, 4'h3, 24'h0, 16'h0, 4'h1, 32'h80};
        rows[1] = '{4'h1, 4'h4, 24'h0, 16'h0, 4'h0, 32'h0};
        rows[2] = '{4'h1, 4'h2, 24'h10, 16'h0, 4'h1, 32'ha501};
        rows[3] = '{4'h1, 4'h6, 24'h0, 16'h0, 4'h0, 32'h0};
        rows[4] = '{4'h1, 4'h1, 24'h555, 16'haa, 4'h2, 32'h0};
        rows[5] = '{4'h2, 4'h1, 24'h2aa, 16'h55, 4'h3, 32'h0};
        rows[6] = '{4'h2, 4'h4, 24'h0, 16'h0, 4'h0, 32'h0};
        rows[7] = '{4'h3, 4'h4, 24'h0, 16'h0, 4'h1, 32'h0};
        rows[8] = '{4'h4, 4'h1, 24'h555, 16'h71, 4'h4, 32'h0};
        rows[9] = '{4'ha, 4'h1, 24'h555, 16'h71, 4'ha, 32'h0};
        rows[10] = '{4'ha, 4'h5, 24'h0, 16'h0, 4'h0, 32'h0};
        rows[11] = '{4'ha, 4'h3, 24'h0, 16'h0, 4'ha, 32'h80};
        rows[12] = '{4'ha, 4'h2, 24'h0, 16'h0, 4'ha, 32'ha50a};
        rows[13] = '{4'ha, 4'h1, 24'h0, 16'ha0, 4'hd, 32'h0};
        rows[14] = '{4'hc, 4'h1, 24'h555, 16'h71, 4'hc, 32'h0};
        rows[15] = '{4'h1, 4'h1, 24'h0, 16'h12, 4'h1, 32'h0};
        rows[16] = '{4'h1, 4'h7, 24'h100, 16'h1234, 4'h7, 32'h0};
        repeat (6) @(posedge clock);
        srst <= 1'b0;
        #1 check("idle pins", {28'h0, ce_n, oe_n, we_n, dq_oe_n}, 32'hf);
        rd(aux_ctl_pkg::REG_STATUS);
        check("status after reset", rd_val, 32'h0);
        rd(4'hf);
        check("unmapped read", rd_val, 32'h0);
        foreach (rows[i])
        begin
            set_state(rows[i].st0);
            run(rows[i].a, rows[i].d, rows[i].op);
            check("device state", {28'h0, state}, {28'h0, rows[i].st1});
            rd(aux_ctl_pkg::REG_RDATA);
            if (rows[i].op inside {aux_ctl_pkg::OP_READ, aux_ctl_pkg::OP_STATUS})
                check("read data", rd_val, rows[i].rd);
        end
        // busy programming refuses reset but answers status
        run(24'h0, 16'h0, aux_ctl_pkg::OP_RESET);
        check("reset while busy", {28'h0, state}, 32'h7);
        run(24'h0, 16'h0, aux_ctl_pkg::OP_STATUS);
        rd(aux_ctl_pkg::REG_RDATA);
        check("busy status", rd_val, 32'h0);
        #2100;
        run(24'h555, 16'h71, aux_ctl_pkg::OP_WRITE);
        check("clear after done", {28'h0, state}, 32'h1);
        // four-word buffer, then a fifth word with none left
        run(24'h300, 16'h3, aux_ctl_pkg::OP_BUF_START);
        check("loading", {28'h0, state}, 32'h6);
        for (int k = 0; k < 4; k++)
            run(24'h300 + 24'(k), 16'h1000, aux_ctl_pkg::OP_BUF_WORD);
        check("buffer programming", {28'h0, state}, 32'h7);
        run(24'h304, 16'h1000, aux_ctl_pkg::OP_BUF_WORD);
        err_is("extra word refused", 1'b1);
        #2100;
        run(24'h555, 16'h71, aux_ctl_pkg::OP_WRITE);
        run(24'h300, 16'h101, aux_ctl_pkg::OP_BUF_START);
        err_is("count too big", 1'b1);
        check("no cycle on refusal", {28'h0, state}, 32'h1);
        err_is("error cleared", 1'b0);
        run(24'h300, 16'h1, aux_ctl_pkg::OP_BUF_START);
        run(24'h400, 16'h0, aux_ctl_pkg::OP_BUF_WORD);
        err_is("word off page", 1'b1);
        check("load kept", {28'h0, state}, 32'h6);
        // back-to-back commands: the second meets a busy engine
        wr(aux_ctl_pkg::REG_CMD, {28'h0, aux_ctl_pkg::OP_READ});
        wr(aux_ctl_pkg::REG_CMD, {28'h0, aux_ctl_pkg::OP_READ});
        poll;
        err_is("command while busy", 1'b1);
        tally_and_finish;
    end
endmodule
